//--- pkg/ccs_pkg.sv
// Purpose: Shared constants and types of the common command and status unit
// Assumes: Commands arrive as ASCII bytes, one line per command, ended by line feed
// Notes: Header codes hold the last four upper-case header characters

package ccs_pkg;

    // ==========================================================
    // Characters
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_QUOTE = 8'h22;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_UA = 8'h41;
    localparam logic [7:0] CH_UZ = 8'h5A;
    localparam logic [7:0] CH_LA = 8'h61;
    localparam logic [7:0] CH_LZ = 8'h7A;
    localparam logic [7:0] CASE_GAP = 8'h20;

    // ==========================================================
    // Header codes
    localparam logic [31:0] H_CLS = 32'h00434C53;
    localparam logic [31:0] H_ESE = 32'h00455345;
    localparam logic [31:0] H_ESEQ = 32'h4553453F;
    localparam logic [31:0] H_ESRQ = 32'h4553523F;
    localparam logic [31:0] H_IDNQ = 32'h49444E3F;
    localparam logic [31:0] H_OPC = 32'h004F5043;
    localparam logic [31:0] H_OPCQ = 32'h4F50433F;
    localparam logic [31:0] H_RST = 32'h00525354;
    localparam logic [31:0] H_SRE = 32'h00535245;
    localparam logic [31:0] H_SREQ = 32'h5352453F;
    localparam logic [31:0] H_STBQ = 32'h5354423F;
    localparam logic [31:0] H_TRG = 32'h00545247;
    localparam logic [31:0] H_WAI = 32'h00574149;

    // ==========================================================
    // Register fields and values
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [7:0] VAL_DONE = 8'h01;
    localparam logic [11:0] PARAM_MAX = 12'h0FF;
    localparam int ESR_OPC = 0;
    localparam int ESR_EXE = 4;
    localparam int ESR_CME = 5;
    localparam int STB_EAV = 2;
    localparam int STB_QSB = 3;
    localparam int STB_ESB = 5;
    localparam int STB_RQS = 6;
    localparam int STB_OSB = 7;

    // Error codes pushed to the external error queue
    localparam logic [7:0] ERR_CMD = 8'h01;
    localparam logic [7:0] ERR_PARAM = 8'h02;
    localparam logic [7:0] ERR_TRIG = 8'h03;

    // Identification text; the value is arbitrary
    localparam int ID_LEN = 30;
    localparam logic [ID_LEN*8-1:0] ID_TEXT = "MAKER,MODEL,00000000,1.0.0/1.0";

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        C_NONE = 4'h0, C_CLS = 4'h1, C_ESE = 4'h2, C_ESEQ = 4'h3, C_ESRQ = 4'h4,
        C_IDNQ = 4'h5, C_OPC = 4'h6, C_OPCQ = 4'h7, C_RST = 4'h8, C_SRE = 4'h9,
        C_SREQ = 4'hA, C_STBQ = 4'hB, C_TRG = 4'hC, C_WAI = 4'hD, C_BAD = 4'hE
    } cmd_t;
    typedef enum logic [1:0] {P_NONE = 2'h0, P_NUM = 2'h1, P_CHAR = 2'h2, P_STR = 2'h3} pkind_t;
    typedef enum logic {R_NUM = 1'b0, R_IDN = 1'b1} resp_t;

endpackage

//--- hdl/reply_text.sv
// Purpose: Gives the character at a position of a reply line
// Assumes: Numbers are 0 to 255, printed without leading zeros
// Notes: Pure combinational; the caller registers the character

`timescale 1ns/1ns
`default_nettype none

module reply_text
    import ccs_pkg::*;
(
    input wire resp_t kind,
    input wire logic [7:0] value,
    input wire logic [5:0] idx,
    output logic [7:0] ch,
    output logic last
);

    logic [7:0] hund, tens, ones, dig;
    logic [5:0] nd;

    always_comb begin
        hund = value / 8'h64;
        tens = (value / 8'h0A) % 8'h0A;
        ones = value % 8'h0A;
        nd = (value >= 8'h64) ? 6'h03 : ((value >= 8'h0A) ? 6'h02 : 6'h01);
        dig = ones;
        if (idx == 6'h00) begin
            dig = (nd == 6'h03) ? hund : ((nd == 6'h02) ? tens : ones);
        end else if (idx == 6'h01) begin
            dig = (nd == 6'h03) ? tens : ones;
        end
        ch = CH_LF;
        last = 1'b0;
        if (kind == R_IDN) begin
            // Fields joined by commas, versions by a slash [RL4]
            if (idx < 6'(ID_LEN)) begin
                ch = ID_TEXT[(ID_LEN - 1 - int'(idx)) * 8 +: 8];
            end else begin
                last = 1'b1;
            end
        end else if (idx < nd) begin
            ch = CH_ZERO + dig;
        end else begin
            last = 1'b1;
        end
    end

endmodule

`default_nettype wire

//--- hdl/common_command_status_unit.sv
// Purpose: Parses common command lines and keeps standard status state
// Assumes: Error queue and other event registers live outside this block
// Notes: Only the last four header characters are decoded; longer headers are rejected
//
// Function
// RL1 - Clear-status zeroes event status, pulses external queue and register clear.
// RL2 - Event enable register is writable, readable, range 0 to 255, zero on preset.
// RL3 - Event status query returns the value then clears the register.
// RL4 - Identification reply is maker, model, serial, software/hardware version.
// RL5 - Operation-complete command sets bit 0 once nothing is pending.
// RL6 - Only a single sweep is pending; other commands finish before the next.
// RL7 - Operation-complete query replies 1 only once nothing is pending.
// RL8 - A header starting with an asterisk marks a common command.
// RL9 - Space separates header from parameters, commas separate parameters.
// RL10 - Bare keywords are character parameters, quoted text is a string parameter.
// RL11 - Service enable register is writable, readable, range 0 to 255, zero on preset.
// RL12 - Bus trigger acts only with bus source and a waiting channel, else error.
// RL13 - Wait command holds off later commands while a single sweep is pending.
// RL14 - Event summary bit set while any enabled event status bit is set.

`timescale 1ns/1ns
`default_nettype none

module common_command_status_unit
    import ccs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    output logic rxReady,
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txReady,
    input wire logic triggerOriginBus,
    input wire logic channelWaiting,
    input wire logic singleSweepStart,
    input wire logic sweepDone,
    input wire logic errQueueNotEmpty,
    input wire logic questSummary,
    input wire logic operSummary,
    output logic busTrigger,
    output logic errorPush,
    output logic [7:0] errorCode,
    output logic statusClear,
    output logic presetPulse,
    output logic [7:0] statusByte,
    output logic [7:0] eventStatus,
    output logic opPending
);

    // ==========================================================
    // State
    typedef enum logic [3:0] {
        S_HEAD = 4'h0, S_SEP = 4'h1, S_NUM = 4'h2, S_CHARP = 4'h3, S_STR = 4'h4,
        S_STREND = 4'h5, S_EXEC = 4'h6, S_WAIT = 4'h7, S_TXLOAD = 4'h8, S_TX = 4'h9
    } state_t;

    typedef struct packed {
        state_t state;
        logic first;
        logic common;
        logic [31:0] hdr;
        pkind_t pkind;
        logic [1:0] nParams;
        logic [7:0] num;
        logic numOvf;
        logic bad;
        logic [7:0] ese;
        logic [7:0] sre;
        logic [7:0] esr;
        logic [7:0] stb;
        logic pending;
        logic opcArmed;
        logic waitQuery;
        resp_t kind;
        logic [7:0] val;
        logic [5:0] idx;
        logic [7:0] txData;
        logic txLast;
        logic errPush;
        logic [7:0] errCode;
        logic busTrig;
        logic clrStatus;
        logic preset;
    } st_t;

    st_t st_q, st_d;
    cmd_t cmd;
    logic [7:0] ch, fmtCh;
    logic [11:0] numMul;
    logic [5:0] fmtIdx;
    logic fmtLast, take, isDigit, isAlpha, argOk, noArg, clsNow, paramErr, cmdErr, trigErr;

    function automatic cmd_t decode(input logic [31:0] h, input logic c);
        cmd_t r;
        r = C_BAD;
        if (!c && h == 32'h00000000) begin
            r = C_NONE;
        end else if (c) begin
            case (h)
                H_CLS: r = C_CLS;
                H_ESE: r = C_ESE;
                H_ESEQ: r = C_ESEQ;
                H_ESRQ: r = C_ESRQ;
                H_IDNQ: r = C_IDNQ;
                H_OPC: r = C_OPC;
                H_OPCQ: r = C_OPCQ;
                H_RST: r = C_RST;
                H_SRE: r = C_SRE;
                H_SREQ: r = C_SREQ;
                H_STBQ: r = C_STBQ;
                H_TRG: r = C_TRG;
                H_WAI: r = C_WAI;
                default: r = C_BAD;
            endcase
        end
        return r;
    endfunction

    // Parsing stops while a command executes, waits or replies [RL6] [RL13]
    assign rxReady = (st_q.state <= S_STREND);
    assign fmtIdx = (st_q.state == S_TXLOAD) ? 6'h00 : st_q.idx + 6'h01;

    reply_text u_text (
        .kind(st_q.kind),
        .value(st_q.val),
        .idx(fmtIdx),
        .ch(fmtCh),
        .last(fmtLast)
    );

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.errPush = 1'b0;
        st_d.busTrig = 1'b0;
        st_d.clrStatus = 1'b0;
        st_d.preset = 1'b0;
        clsNow = 1'b0;
        paramErr = 1'b0;
        cmdErr = 1'b0;
        trigErr = 1'b0;
        take = rxValid && rxReady;
        ch = (rxData >= CH_LA && rxData <= CH_LZ) ? rxData - CASE_GAP : rxData;
        isDigit = (ch >= CH_ZERO && ch <= CH_NINE);
        isAlpha = (ch >= CH_UA && ch <= CH_UZ);
        numMul = {4'h0, st_q.num} * 12'h00A + {4'h0, ch - CH_ZERO};
        cmd = decode(st_q.hdr, st_q.common);
        argOk = st_q.nParams == 2'h1 && st_q.pkind == P_NUM && !st_q.numOvf && !st_q.bad;
        noArg = st_q.nParams == 2'h0 && !st_q.bad;
        // Set wins over clear: start and done in one cycle leaves it pending [RL6]
        st_d.pending = singleSweepStart | (st_q.pending & ~sweepDone);
        case (st_q.state)
            S_HEAD: if (take) begin
                st_d.first = 1'b0;
                if (ch == CH_LF) begin
                    st_d.state = S_EXEC;
                end else if (ch == CH_SPACE) begin
                    st_d.state = S_SEP; // [RL9]
                end else if (st_q.first && ch == CH_STAR) begin
                    st_d.common = 1'b1; // [RL8]
                end else begin
                    st_d.hdr = {st_q.hdr[23:0], ch};
                    st_d.bad = st_q.bad | (st_q.hdr[31:24] != 8'h00);
                end
            end
            S_SEP: if (take) begin
                if (ch == CH_LF) begin
                    st_d.state = S_EXEC;
                end else if (ch != CH_SPACE) begin
                    st_d.nParams = (st_q.nParams == 2'h3) ? 2'h3 : st_q.nParams + 2'h1;
                    // Type is chosen by the first character [RL10]
                    if (isDigit) begin
                        st_d.state = S_NUM;
                        st_d.pkind = P_NUM;
                        st_d.num = ch - CH_ZERO;
                    end else if (ch == CH_QUOTE) begin
                        st_d.state = S_STR;
                        st_d.pkind = P_STR;
                    end else if (isAlpha) begin
                        st_d.state = S_CHARP;
                        st_d.pkind = P_CHAR;
                    end else begin
                        st_d.bad = 1'b1;
                    end
                end
            end
            S_NUM, S_CHARP, S_STREND: if (take) begin
                if (ch == CH_LF) begin
                    st_d.state = S_EXEC;
                end else if (ch == CH_COMMA) begin
                    st_d.state = S_SEP; // [RL9]
                end else if (st_q.state == S_NUM && isDigit) begin
                    st_d.num = numMul[7:0];
                    st_d.numOvf = st_q.numOvf | (numMul > PARAM_MAX);
                end else if (!(st_q.state == S_CHARP && (isAlpha || isDigit))) begin
                    st_d.bad = 1'b1;
                end
            end
            S_STR: if (take) begin
                // Commas and spaces inside quotes belong to the string [RL10]
                if (ch == CH_QUOTE) begin
                    st_d.state = S_STREND;
                end else if (ch == CH_LF) begin
                    st_d.state = S_EXEC;
                    st_d.bad = 1'b1;
                end
            end
            S_EXEC: begin
                st_d.state = S_HEAD;
                st_d.first = 1'b1;
                st_d.common = 1'b0;
                st_d.hdr = 32'h00000000;
                st_d.pkind = P_NONE;
                st_d.nParams = 2'h0;
                st_d.num = 8'h00;
                st_d.numOvf = 1'b0;
                st_d.bad = 1'b0;
                st_d.kind = R_NUM;
                case (cmd)
                    C_NONE: ;
                    C_CLS: if (noArg) begin
                        st_d.esr = 8'h00; // [RL1]
                        st_d.clrStatus = 1'b1; // [RL1]
                        st_d.opcArmed = 1'b0;
                        clsNow = 1'b1;
                    end else paramErr = 1'b1;
                    C_ESE: if (argOk) st_d.ese = st_q.num; else paramErr = 1'b1; // [RL2]
                    C_SRE: if (argOk) st_d.sre = st_q.num; else paramErr = 1'b1; // [RL11]
                    C_ESEQ, C_SREQ, C_STBQ, C_ESRQ, C_IDNQ: if (noArg) begin
                        st_d.state = S_TXLOAD;
                        st_d.val = (cmd == C_ESEQ) ? st_q.ese : // [RL2]
                                   (cmd == C_SREQ) ? st_q.sre : // [RL11]
                                   (cmd == C_STBQ) ? st_q.stb : st_q.esr; // [RL3]
                        if (cmd == C_ESRQ) st_d.esr = 8'h00; // [RL3]
                        if (cmd == C_IDNQ) st_d.kind = R_IDN; // [RL4]
                    end else paramErr = 1'b1;
                    C_OPC: if (noArg) st_d.opcArmed = 1'b1; else paramErr = 1'b1; // [RL5]
                    C_OPCQ, C_WAI: if (noArg) begin
                        st_d.state = S_WAIT; // [RL7] [RL13]
                        st_d.waitQuery = (cmd == C_OPCQ);
                    end else paramErr = 1'b1;
                    C_RST: if (noArg) begin
                        st_d.ese = ESE_RST; // [RL2]
                        st_d.sre = SRE_RST; // [RL11]
                        st_d.opcArmed = 1'b0;
                        st_d.preset = 1'b1;
                    end else paramErr = 1'b1;
                    C_TRG: if (!noArg) begin
                        paramErr = 1'b1;
                    end else if (triggerOriginBus && channelWaiting) begin
                        st_d.busTrig = 1'b1; // [RL12]
                    end else trigErr = 1'b1; // [RL12]
                    default: cmdErr = 1'b1; // [RL8]
                endcase
            end
            S_WAIT: if (!st_q.pending) begin
                // No-op when nothing is pending: this exits next cycle [RL13]
                st_d.state = st_q.waitQuery ? S_TXLOAD : S_HEAD;
                st_d.val = VAL_DONE; // [RL7]
            end
            S_TXLOAD: begin
                st_d.state = S_TX;
                st_d.idx = 6'h00;
                st_d.txData = fmtCh;
                st_d.txLast = fmtLast;
            end
            S_TX: if (txReady) begin
                if (st_q.txLast) begin
                    st_d.state = S_HEAD;
                end else begin
                    st_d.idx = fmtIdx;
                    st_d.txData = fmtCh;
                    st_d.txLast = fmtLast;
                end
            end
            default: st_d.state = S_HEAD;
        endcase
        if (paramErr || cmdErr || trigErr) begin
            st_d.errPush = 1'b1;
            st_d.errCode = cmdErr ? ERR_CMD : (paramErr ? ERR_PARAM : ERR_TRIG);
            st_d.esr[ESR_CME] = st_d.esr[ESR_CME] | cmdErr;
            st_d.esr[ESR_EXE] = st_d.esr[ESR_EXE] | paramErr | trigErr;
        end
        // Applied after the read clear, so a completion in that cycle survives [RL5]
        if (st_q.opcArmed && !st_q.pending && !clsNow) begin
            st_d.esr[ESR_OPC] = 1'b1; // [RL5]
            st_d.opcArmed = 1'b0;
        end
        st_d.stb = 8'h00;
        st_d.stb[STB_EAV] = errQueueNotEmpty;
        st_d.stb[STB_QSB] = questSummary;
        st_d.stb[STB_ESB] = |(st_d.esr & st_d.ese); // [RL14]
        st_d.stb[STB_OSB] = operSummary;
        st_d.stb[STB_RQS] = |(st_d.stb & st_d.sre);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
            st_q.first <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign txValid = (st_q.state == S_TX);
    assign txData = st_q.txData;
    assign busTrigger = st_q.busTrig;
    assign errorPush = st_q.errPush;
    assign errorCode = st_q.errCode;
    assign statusClear = st_q.clrStatus;
    assign presetPulse = st_q.preset;
    assign statusByte = st_q.stb;
    assign eventStatus = st_q.esr;
    assign opPending = st_q.pending;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic isExec;
    assign isExec = (st_q.state == S_EXEC);

    property p_clsClear;
        isExec && cmd == C_CLS && noArg |=> st_q.esr == 8'h00 && statusClear;
    endproperty
    a_clsClear: assert property (p_clsClear) else $error("clear status left state"); // [RL1]

    property p_eseWrite;
        isExec && cmd == C_ESE && argOk |=> st_q.ese == $past(st_q.num);
    endproperty
    a_eseWrite: assert property (p_eseWrite) else $error("event enable not written"); // [RL2]

    property p_esrRead;
        isExec && cmd == C_ESRQ && noArg |=> st_q.val == $past(st_q.esr) && st_q.esr[7:1] == 7'h00;
    endproperty
    a_esrRead: assert property (p_esrRead) else $error("event status read wrong"); // [RL3]

    property p_idnFirst;
        st_q.state == S_TXLOAD && st_q.kind == R_IDN |=> txValid && txData == ID_TEXT[ID_LEN*8-1 -: 8];
    endproperty
    a_idnFirst: assert property (p_idnFirst) else $error("identification start wrong"); // [RL4]

    property p_opcSet;
        $rose(st_q.esr[ESR_OPC]) |-> $past(st_q.opcArmed) && !$past(st_q.pending);
    endproperty
    a_opcSet: assert property (p_opcSet) else $error("completion bit set early"); // [RL5]

    property p_pendOnlySweep;
        $rose(opPending) |-> $past(singleSweepStart);
    endproperty
    a_pendOnlySweep: assert property (p_pendOnlySweep) else $error("pending without sweep"); // [RL6]

    sequence s_waitDone;
        st_q.state == S_WAIT && st_q.waitQuery && !st_q.pending;
    endsequence
    sequence s_replyOne;
        st_q.state == S_TXLOAD ##1 (txValid && txData == CH_ZERO + VAL_DONE);
    endsequence
    property p_opcReply;
        s_waitDone |=> s_replyOne;
    endproperty
    a_opcReply: assert property (p_opcReply) else $error("completion reply wrong"); // [RL7]

    property p_holdOff;
        st_q.state == S_WAIT && opPending |=> !rxReady;
    endproperty
    a_holdOff: assert property (p_holdOff) else $error("input taken while busy"); // [RL13]

    property p_trigGate;
        busTrigger |-> $past(triggerOriginBus && channelWaiting);
    endproperty
    a_trigGate: assert property (p_trigGate) else $error("bus trigger not gated"); // [RL12]

    property p_summary;
        statusByte[STB_ESB] == |(eventStatus & st_q.ese);
    endproperty
    a_summary: assert property (p_summary) else $error("event summary wrong"); // [RL14]

    property p_uncommon;
        isExec && !st_q.common && st_q.hdr != 32'h00000000 |=> errorPush && errorCode == ERR_CMD;
    endproperty
    a_uncommon: assert property (p_uncommon) else $error("non common header accepted"); // [RL8]

endmodule

`default_nettype wire

//--- sim/host_model.sv
// Purpose: Host side of the command line and reply buses
// Assumes: One line in flight at a time
// Notes: Released data shows the inverse of the last character
`timescale 1ns/1ns
`default_nettype none
module host_model
    import ccs_pkg::*;
(
    input wire logic clk,
    input wire logic rxReady,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady
);
    // ==========================================================
    // Transfers
    initial begin
        rxData = 8'h00;
        rxValid = 1'b0;
        txReady = 1'b0;
    end
    // Lines carry asterisk, space and comma as given
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(negedge clk);
            rxData = s[i];
            rxValid = 1'b1;
            do @(posedge clk); while (rxReady !== 1'b1);
        end
        @(negedge clk);
        rxValid = 1'b0;
        rxData = ~rxData;
    endtask
    // The host waits for the whole reply before going on
    task automatic get(output string r);
        r = "";
        @(negedge clk);
        txReady = 1'b1;
        forever begin
            @(posedge clk);
            if (txValid === 1'b1) begin
                if (txData === CH_LF) break;
                r = {r, string'(txData)};
            end
        end
        @(negedge clk);
        txReady = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: Self-checking bench of the common command and status unit
// Assumes: Host model drives both byte buses
// Notes: Summary inputs stay low, so status bits 2, 3 and 7 go unchecked
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import ccs_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] rxData, txData, errorCode, statusByte, eventStatus;
    logic rxValid, rxReady, txValid, txReady, busTrigger, errorPush, statusClear, opPending;
    logic presetPulse;
    logic originBus = 1'b0;
    logic chanWait = 1'b0;
    logic sweepGo = 1'b0;
    logic sweepEnd = 1'b0;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int errCnt = 0;
    int trgCnt = 0;
    int clrCnt = 0;
    int rstCnt = 0;
    string r;
    // ==========================================================
    // Clock, design and monitors
    always #25 clk = ~clk;
    common_command_status_unit dut_u (.clk(clk), .rstn(rstn), .rxData(rxData),
        .rxValid(rxValid), .rxReady(rxReady), .txData(txData), .txValid(txValid),
        .txReady(txReady), .triggerOriginBus(originBus), .channelWaiting(chanWait),
        .singleSweepStart(sweepGo), .sweepDone(sweepEnd), .errQueueNotEmpty(1'b0),
        .questSummary(1'b0), .operSummary(1'b0), .busTrigger(busTrigger),
        .errorPush(errorPush), .errorCode(errorCode), .statusClear(statusClear),
        .presetPulse(presetPulse), .statusByte(statusByte), .eventStatus(eventStatus),
        .opPending(opPending));
    host_model host_u (.clk(clk), .rxReady(rxReady), .rxData(rxData), .rxValid(rxValid),
        .txData(txData), .txValid(txValid), .txReady(txReady));
    // Pulses are counted so that equal error codes in a row stay distinct
    always @(posedge clk) begin
        cyc++;
        if (errorPush === 1'b1) errCnt++;
        if (busTrigger === 1'b1) trgCnt++;
        if (statusClear === 1'b1) clrCnt++;
        if (presetPulse === 1'b1) rstCnt++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    // ==========================================================
    // Helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic chks(input string n, input string e, input string g);
        cmp_count++;
        if (g != e) begin
            fail_count++;
            $display("[ERR] %s expected %s seen %s", n, e, g);
        end
    endtask
    task automatic cmd(input string s);
        host_u.send(s);
        for (int i = 0; i < 60 && rxReady !== 1'b1; i++) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic qry(input string s, input string e);
        host_u.send(s);
        host_u.get(r);
        chks("reply", e, r);
        @(negedge clk);
    endtask
    task automatic sweep(input logic go);
        @(negedge clk);
        sweepGo = go;
        sweepEnd = ~go;
        @(negedge clk);
        sweepGo = 1'b0;
        sweepEnd = 1'b0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_enable();
        qry("*ESE?\n", "0");
        cmd("*ESE 255\n");
        qry("*ESE?\n", "255");
        cmd("*SRE 255\n");
        qry("*SRE?\n", "255");
        cmd("*RST\n");
        chk("presets", 1, rstCnt);
        qry("*ESE?\n", "0");
        qry("*SRE?\n", "0");
        qry("*IDN?\n", "MAKER,MODEL,00000000,1.0.0/1.0");
    endtask
    task automatic t_refuse();
        int n;
        string bad[3] = '{"*ESE ON\n", "*SRE \"7\"\n", "*ESE 1,2\n"};
        cmd("*ESE 16\n");
        n = errCnt;
        cmd("*ESE 256\n");
        chk("errors", n + 1, errCnt);
        chk("errorCode", ERR_PARAM, errorCode);
        chk("eseSummary", 1, statusByte[STB_ESB]);
        qry("*STB?\n", "32");
        cmd("*SRE 32\n");
        qry("*STB?\n", "96");
        qry("*ESR?\n", "16");
        chk("eventStatus", 0, eventStatus);
        chk("eseSummary", 0, statusByte[STB_ESB]);
        cmd("ESE 5\n");
        chk("errorCode", ERR_CMD, errorCode);
        chk("cmdError", 1, eventStatus[ESR_CME]);
        foreach (bad[i]) begin
            n = errCnt;
            cmd(bad[i]);
            chk("errors", n + 1, errCnt);
            chk("errorCode", ERR_PARAM, errorCode);
        end
        qry("*ESE?\n", "16");
    endtask
    task automatic t_opc();
        sweep(1'b1);
        chk("opPending", 1, opPending);
        cmd("*OPC\n");
        chk("opcBit", 0, eventStatus[ESR_OPC]);
        sweep(1'b0);
        repeat (3) @(negedge clk);
        chk("opcBit", 1, eventStatus[ESR_OPC]);
        cmd("*CLS\n");
        chk("eventStatus", 0, eventStatus);
        chk("clears", 1, clrCnt);
        sweep(1'b1);
        host_u.send("*OPC?\n");
        repeat (10) @(negedge clk);
        chk("txValid", 0, txValid);
        sweep(1'b0);
        host_u.get(r);
        chks("reply", "1", r);
        sweep(1'b1);
        host_u.send("*WAI\n");
        repeat (10) @(negedge clk);
        chk("rxReady", 0, rxReady);
        sweep(1'b0);
        repeat (4) @(negedge clk);
        chk("rxReady", 1, rxReady);
        cmd("*WAI\n");
        qry("*OPC?\n", "1");
    endtask
    task automatic t_trig();
        int n;
        n = errCnt;
        chanWait = 1'b1;
        cmd("*TRG\n");
        chk("errorCode", ERR_TRIG, errorCode);
        originBus = 1'b1;
        chanWait = 1'b0;
        cmd("*TRG\n");
        chk("errors", n + 2, errCnt);
        chanWait = 1'b1;
        cmd("*TRG\n");
        chk("triggers", 1, trgCnt);
        chk("errors", n + 2, errCnt);
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_enable();
        t_refuse();
        t_opc();
        t_trig();
        wrap_up();
    end
endmodule
`default_nettype wire
